// ===== lsisc_pkg.sv
// package: constants, layouts and carriers for link status and straps
package lsisc_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_FREQ_HZ = 200_000_000;
    localparam int unsigned BLINK_INTERVAL_MS = 200;
    localparam int unsigned BLINK_CYCLES =
        (CLK_FREQ_HZ / 1000) * BLINK_INTERVAL_MS;

    // ------------------------------------------------------------
    // ports and pins
    // ------------------------------------------------------------
    localparam int unsigned NUM_PORTS = 6;
    localparam int unsigned GPIO_SEL_W = 5;
    localparam logic [4:0] GPIO_SEL_INDICATOR = 5'h0B;
    localparam int unsigned STRAP_TEST_BIT = 0;
    localparam int unsigned STRAP_DEBUG_BIT = 1;
    localparam int unsigned STRAP_IND_DIS_BIT = 3;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] CONTROL_OFS = 8'h00;
    localparam logic [7:0] STRAP_STATUS_OFS = 8'h04;
    localparam logic [7:0] LINK_STATUS_OFS = 8'h08;
    localparam logic [7:0] CAPABILITY_OFS = 8'h0C;
    localparam int unsigned REG_ADDR_W = 8;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int unsigned CTRL_GPIO_SEL_LSB = 0;
    localparam logic [4:0] CTRL_GPIO_SEL_RST = 5'h0B;
    localparam int unsigned ST_TEST_POS = 0;
    localparam int unsigned ST_DEBUG_DIS_POS = 1;
    localparam int unsigned ST_IND_DIS_POS = 3;
    localparam int unsigned ST_VC1_POS = 8;
    localparam int unsigned ST_RXPOL_POS = 9;
    localparam int unsigned ST_PAYLOAD_POS = 10;
    localparam int unsigned ST_CAPTURED_POS = 16;
    localparam int unsigned LS_IND_LSB = 0;
    localparam int unsigned LS_UP_LSB = 8;
    localparam int unsigned LS_FAST_LSB = 16;
    localparam int unsigned LS_VALID_POS = 24;
    localparam int unsigned LS_PHASE_POS = 25;
    localparam int unsigned CAP_VC1_POS = 0;
    localparam int unsigned CAP_SHARE_POS = 1;
    localparam int unsigned CAP_POLDET_POS = 2;
    localparam int unsigned CAP_DEBUG_POS = 3;
    localparam int unsigned CAP_MPS_LSB = 4;
    localparam logic [2:0] MPS_256B = 3'h1;
    localparam logic [2:0] MPS_512B = 3'h2;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic test_strap;
        logic debug_mode_disable_strap;
        logic indicator_output_disable;
        logic second_virtual_channel_enable;
        logic receive_polarity_detect_disable;
        logic large_payload_select;
    } lsisc_strap_s;

    typedef struct packed {
        logic second_vc_offered;
        logic vc_sharing_available;
        logic polarity_detect_enabled;
        logic debug_mode;
        logic [2:0] max_payload_code;
    } lsisc_cfg_s;

endpackage

// ===== lsisc_strap_capture.sv
// module: one-time capture of strap levels after reset release
`timescale 1ns/1ps
module lsisc_strap_capture (
    input wire logic clk,
    input wire logic rst_b,
    input wire lsisc_pkg::lsisc_strap_s strap_pins,
    output lsisc_pkg::lsisc_strap_s strap_held,
    output logic captured
);

    // ------------------------------------------------------------
    // capture at first edge after release, then hold
    // ------------------------------------------------------------
    lsisc_pkg::lsisc_strap_s strap_reg;
    logic captured_reg;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            strap_reg <= '0;
        end else if (!captured_reg) begin
            strap_reg <= strap_pins;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            captured_reg <= 1'b0;
        end else begin
            captured_reg <= 1'b1;
        end
    end

    assign strap_held = strap_reg;
    assign captured = captured_reg;

endmodule

// ===== lsisc_blink_timer.sv
// module: free-running blink phase generator
`timescale 1ns/1ps
module lsisc_blink_timer #(
    parameter int unsigned INTERVAL_CYCLES = lsisc_pkg::BLINK_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    output logic phase
);

    localparam int unsigned CNT_W = $clog2(INTERVAL_CYCLES);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(INTERVAL_CYCLES - 1);

    generate
        if (INTERVAL_CYCLES < 2) begin : g_bad
            $error("blink interval must be at least two cycles");
        end
    endgenerate

    // ------------------------------------------------------------
    // interval counter and phase toggle
    // ------------------------------------------------------------
    logic [CNT_W-1:0] cnt_reg;
    logic phase_reg;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg <= '0;
        end else if (cnt_reg == LAST) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + CNT_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_reg <= 1'b1;
        end else if (cnt_reg == LAST) begin
            phase_reg <= ~phase_reg;
        end
    end

    assign phase = phase_reg;

endmodule

// ===== lsisc_top.sv
// module: link status indicators, strap configuration and ahb-lite regs
`timescale 1ns/1ps
module lsisc_top #(
    parameter int unsigned BLINK_CYCLES = lsisc_pkg::BLINK_CYCLES,
    parameter int unsigned NUM_PORTS = lsisc_pkg::NUM_PORTS
) (
    input wire logic SYS_CLK,
    input wire logic RST_B,
    // ahb-lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // link state from each port
    input wire logic [NUM_PORTS-1:0] LINK_UP,
    input wire logic [NUM_PORTS-1:0] LINK_FAST,
    // indicator pins, shared with straps during init
    input wire logic [NUM_PORTS-1:0] LINK_STATE_INDICATOR_I,
    output logic [NUM_PORTS-1:0] LINK_STATE_INDICATOR_O,
    output logic [NUM_PORTS-1:0] LINK_STATE_INDICATOR_OE_B,
    // dedicated strap pins
    input wire logic SECOND_VIRTUAL_CHANNEL_ENABLE,
    input wire logic RECEIVE_POLARITY_DETECT_DISABLE,
    input wire logic LARGE_PAYLOAD_SELECT,
    // configuration derived from straps
    output logic SECOND_VC_OFFERED,
    output logic VC_SHARING_AVAILABLE,
    output logic POLARITY_DETECT_ENABLED,
    output logic DEBUG_MODE,
    output logic [2:0] MAX_PAYLOAD_CODE
);

    generate
        if (NUM_PORTS != 6) begin : g_bad_ports
            $error("indicator layout serves exactly six ports");
        end
    endgenerate

    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------
    function automatic logic is_offset(
        input logic [lsisc_pkg::REG_ADDR_W-1:0] addr,
        input logic [lsisc_pkg::REG_ADDR_W-1:0] ofs
    );
        is_offset = (addr == ofs);
    endfunction

    function automatic logic indicator_level(
        input logic up,
        input logic fast,
        input logic phase
    );
        if (!up) begin
            indicator_level = 1'b1;
        end else if (fast) begin
            indicator_level = 1'b0;
        end else begin
            indicator_level = phase;
        end
    endfunction

    // ------------------------------------------------------------
    // strap capture
    // ------------------------------------------------------------
    lsisc_pkg::lsisc_strap_s strap_pins;
    lsisc_pkg::lsisc_strap_s strap_held;
    logic straps_captured;

    always_comb begin
        strap_pins.test_strap =
            LINK_STATE_INDICATOR_I[lsisc_pkg::STRAP_TEST_BIT];
        strap_pins.debug_mode_disable_strap =
            LINK_STATE_INDICATOR_I[lsisc_pkg::STRAP_DEBUG_BIT];
        strap_pins.indicator_output_disable =
            LINK_STATE_INDICATOR_I[lsisc_pkg::STRAP_IND_DIS_BIT];
        strap_pins.second_virtual_channel_enable =
            SECOND_VIRTUAL_CHANNEL_ENABLE;
        strap_pins.receive_polarity_detect_disable =
            RECEIVE_POLARITY_DETECT_DISABLE;
        strap_pins.large_payload_select = LARGE_PAYLOAD_SELECT;
    end

    lsisc_strap_capture i_lsisc_strap_capture (
        .clk(SYS_CLK),
        .rst_b(RST_B),
        .strap_pins(strap_pins),
        .strap_held(strap_held),
        .captured(straps_captured)
    );

    // ------------------------------------------------------------
    // configuration from straps
    // ------------------------------------------------------------
    lsisc_pkg::lsisc_cfg_s cfg_next;
    lsisc_pkg::lsisc_cfg_s cfg_reg;

    always_comb begin
        cfg_next.second_vc_offered =
            strap_held.second_virtual_channel_enable;
        cfg_next.vc_sharing_available =
            ~strap_held.second_virtual_channel_enable;
        cfg_next.polarity_detect_enabled =
            ~strap_held.receive_polarity_detect_disable;
        cfg_next.debug_mode = ~strap_held.debug_mode_disable_strap;
        cfg_next.max_payload_code = strap_held.large_payload_select ?
            lsisc_pkg::MPS_512B : lsisc_pkg::MPS_256B;
    end

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            cfg_reg <= '0;
        end else if (straps_captured) begin
            cfg_reg <= cfg_next;
        end
    end

    assign SECOND_VC_OFFERED = cfg_reg.second_vc_offered;
    assign VC_SHARING_AVAILABLE = cfg_reg.vc_sharing_available;
    assign POLARITY_DETECT_ENABLED = cfg_reg.polarity_detect_enabled;
    assign DEBUG_MODE = cfg_reg.debug_mode;
    assign MAX_PAYLOAD_CODE = cfg_reg.max_payload_code;

    // ------------------------------------------------------------
    // blink timing
    // ------------------------------------------------------------
    logic blink_phase;

    lsisc_blink_timer #(
        .INTERVAL_CYCLES(BLINK_CYCLES)
    ) i_lsisc_blink_timer (
        .clk(SYS_CLK),
        .rst_b(RST_B),
        .phase(blink_phase)
    );

    // ------------------------------------------------------------
    // ahb-lite address phase
    // ------------------------------------------------------------
    logic [lsisc_pkg::GPIO_SEL_W-1:0] gpio_sel_reg;
    logic [lsisc_pkg::REG_ADDR_W-1:0] wr_addr_reg;
    logic wr_pend_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [NUM_PORTS-1:0] ind_level_reg;
    logic indicators_valid;
    logic access;
    logic [lsisc_pkg::REG_ADDR_W-1:0] req_addr;

    assign access = HSEL & HTRANS[1] & HREADY;
    assign req_addr = HADDR[lsisc_pkg::REG_ADDR_W-1:0];

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            wr_pend_reg <= 1'b0;
        end else begin
            wr_pend_reg <= access & HWRITE & (HSIZE == 3'h2);
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            wr_addr_reg <= '0;
        end else if (access) begin
            wr_addr_reg <= req_addr;
        end
    end

    // ------------------------------------------------------------
    // read data, sampled in the address phase
    // ------------------------------------------------------------
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (is_offset(req_addr, lsisc_pkg::CONTROL_OFS)) begin
            rdata_next[lsisc_pkg::CTRL_GPIO_SEL_LSB +: lsisc_pkg::GPIO_SEL_W]
                = gpio_sel_reg;
        end else if (is_offset(req_addr, lsisc_pkg::STRAP_STATUS_OFS)) begin
            rdata_next[lsisc_pkg::ST_TEST_POS] = strap_held.test_strap;
            rdata_next[lsisc_pkg::ST_DEBUG_DIS_POS] =
                strap_held.debug_mode_disable_strap;
            rdata_next[lsisc_pkg::ST_IND_DIS_POS] =
                strap_held.indicator_output_disable;
            rdata_next[lsisc_pkg::ST_VC1_POS] =
                strap_held.second_virtual_channel_enable;
            rdata_next[lsisc_pkg::ST_RXPOL_POS] =
                strap_held.receive_polarity_detect_disable;
            rdata_next[lsisc_pkg::ST_PAYLOAD_POS] =
                strap_held.large_payload_select;
            rdata_next[lsisc_pkg::ST_CAPTURED_POS] = straps_captured;
        end else if (is_offset(req_addr, lsisc_pkg::LINK_STATUS_OFS)) begin
            rdata_next[lsisc_pkg::LS_IND_LSB +: 6] = ind_level_reg;
            rdata_next[lsisc_pkg::LS_UP_LSB +: 6] = LINK_UP;
            rdata_next[lsisc_pkg::LS_FAST_LSB +: 6] = LINK_FAST;
            rdata_next[lsisc_pkg::LS_VALID_POS] = indicators_valid;
            rdata_next[lsisc_pkg::LS_PHASE_POS] = blink_phase;
        end else if (is_offset(req_addr, lsisc_pkg::CAPABILITY_OFS)) begin
            rdata_next[lsisc_pkg::CAP_VC1_POS] = cfg_reg.second_vc_offered;
            rdata_next[lsisc_pkg::CAP_SHARE_POS] =
                cfg_reg.vc_sharing_available;
            rdata_next[lsisc_pkg::CAP_POLDET_POS] =
                cfg_reg.polarity_detect_enabled;
            rdata_next[lsisc_pkg::CAP_DEBUG_POS] = cfg_reg.debug_mode;
            rdata_next[lsisc_pkg::CAP_MPS_LSB +: 3] =
                cfg_reg.max_payload_code;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            rdata_reg <= 32'h0000_0000;
        end else if (access & ~HWRITE) begin
            rdata_reg <= rdata_next;
        end
    end

    assign HRDATA = rdata_reg;
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;

    // ------------------------------------------------------------
    // control register write, data phase
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            gpio_sel_reg <= lsisc_pkg::CTRL_GPIO_SEL_RST;
        end else if (wr_pend_reg &&
                     is_offset(wr_addr_reg, lsisc_pkg::CONTROL_OFS)) begin
            gpio_sel_reg <= HWDATA[lsisc_pkg::CTRL_GPIO_SEL_LSB +:
                                   lsisc_pkg::GPIO_SEL_W];
        end
    end

    // ------------------------------------------------------------
    // indicator generation
    // ------------------------------------------------------------
    assign indicators_valid = straps_captured &
        ~strap_held.indicator_output_disable &
        (gpio_sel_reg == lsisc_pkg::GPIO_SEL_INDICATOR);

    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++) begin : g_port
            always_ff @(posedge SYS_CLK or negedge RST_B) begin
                if (!RST_B) begin
                    ind_level_reg[p] <= 1'b1;
                end else begin
                    ind_level_reg[p] <= indicator_level(
                        LINK_UP[p], LINK_FAST[p], blink_phase);
                end
            end

            always_ff @(posedge SYS_CLK or negedge RST_B) begin
                if (!RST_B) begin
                    LINK_STATE_INDICATOR_OE_B[p] <= 1'b1;
                end else begin
                    LINK_STATE_INDICATOR_OE_B[p] <= ~indicators_valid;
                end
            end
        end
    endgenerate

    assign LINK_STATE_INDICATOR_O = ind_level_reg;

endmodule

// ===== lsisc_board.sv
// partner model: board strap resistors and indicator lamps
`timescale 1ns/1ps
module lsisc_board (
    input wire logic [5:0] ind_o,
    input wire logic [5:0] ind_oe_b,
    input wire logic dbg_lvl,
    input wire logic dis_lvl,
    output logic [5:0] ind_pin
);
    // --------
    // released pins
    // --------
    logic [5:0] last_q = 6'h00;
    logic [5:0] float_lvl;

    always @(ind_o or ind_oe_b) begin
        last_q = (last_q & ind_oe_b) | (ind_o & ~ind_oe_b);
    end

    // lamps float to the inverse, straps by resistor, test pin pulled up
    assign float_lvl = {~last_q[5:4], dis_lvl, ~last_q[2], dbg_lvl, 1'h1};
    assign ind_pin = (ind_o & ~ind_oe_b) | (float_lvl & ind_oe_b);
endmodule

// ===== lsisc_top_chk.sv
// checker: port assertions for link indicators and strap capture
`timescale 1ns/1ps
module lsisc_chk #(
    parameter int unsigned BLINK_CYCLES = 8,
    parameter int unsigned NUM_PORTS = 6
) (
    input wire logic SYS_CLK,
    input wire logic RST_B,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    input wire logic [NUM_PORTS-1:0] LINK_UP,
    input wire logic [NUM_PORTS-1:0] LINK_FAST,
    input wire logic [NUM_PORTS-1:0] LINK_STATE_INDICATOR_I,
    input wire logic [NUM_PORTS-1:0] LINK_STATE_INDICATOR_O,
    input wire logic [NUM_PORTS-1:0] LINK_STATE_INDICATOR_OE_B,
    input wire logic SECOND_VIRTUAL_CHANNEL_ENABLE,
    input wire logic RECEIVE_POLARITY_DETECT_DISABLE,
    input wire logic LARGE_PAYLOAD_SELECT,
    input wire logic SECOND_VC_OFFERED,
    input wire logic VC_SHARING_AVAILABLE,
    input wire logic POLARITY_DETECT_ENABLED,
    input wire logic DEBUG_MODE,
    input wire logic [2:0] MAX_PAYLOAD_CODE
);
    // --------
    // helper state
    // --------
    logic [1:0] age_reg;
    logic [4:0] cap_reg;
    logic wr_reg;
    logic [4:0] sel_reg;
    logic [3:0] quiet_reg;
    logic o_reg;
    logic [7:0] stay_reg;
    logic [7:0] run_reg;

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            age_reg <= 2'h0;
            cap_reg <= 5'h00;
        end else begin
            if (age_reg != 2'h3) age_reg <= age_reg + 2'h1;
            if (age_reg == 2'h0) cap_reg <= {LINK_STATE_INDICATOR_I[1],
                LINK_STATE_INDICATOR_I[3], SECOND_VIRTUAL_CHANNEL_ENABLE,
                RECEIVE_POLARITY_DETECT_DISABLE, LARGE_PAYLOAD_SELECT};
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            wr_reg <= 1'h0;
            sel_reg <= lsisc_pkg::CTRL_GPIO_SEL_RST;
            quiet_reg <= 4'h0;
        end else begin
            wr_reg <= HSEL && HTRANS[1] && HREADY && HWRITE && HSIZE == 3'h2
                && HADDR[7:0] == lsisc_pkg::CONTROL_OFS;
            if (wr_reg) begin
                sel_reg <= HWDATA[4:0];
                quiet_reg <= 4'h0;
            end else if (quiet_reg != 4'hF) begin
                quiet_reg <= quiet_reg + 4'h1;
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            o_reg <= 1'h1;
            stay_reg <= 8'h00;
            run_reg <= 8'h00;
        end else begin
            o_reg <= LINK_STATE_INDICATOR_O[2];
            if (LINK_STATE_INDICATOR_O[2] != o_reg) stay_reg <= 8'h01;
            else if (stay_reg != 8'hFF) stay_reg <= stay_reg + 8'h01;
            if (!LINK_UP[2] || LINK_FAST[2]) run_reg <= 8'h00;
            else if (run_reg != 8'hFF) run_reg <= run_reg + 8'h01;
        end
    end

    // --------
    // properties
    // --------
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_B);

    sequence s_settled;
        age_reg >= 2'h2;
    endsequence
    sequence s_blinking;
        run_reg > 8'(2 * BLINK_CYCLES + 2);
    endsequence

    property p_down;
        age_reg != 2'h0 |-> (~$past(LINK_UP) & ~LINK_STATE_INDICATOR_O) == '0;
    endproperty
    a_down: assert property (p_down)
        else $error("indicator not high for a down link");
    property p_fast;
        age_reg != 2'h0 |->
            ($past(LINK_UP) & $past(LINK_FAST) & LINK_STATE_INDICATOR_O) == '0;
    endproperty
    a_fast: assert property (p_fast)
        else $error("indicator not low for a fast link");
    property p_blink;
        s_blinking |-> stay_reg <= 8'(BLINK_CYCLES) && (stay_reg ==
            8'(BLINK_CYCLES) || LINK_STATE_INDICATOR_O[2] == o_reg);
    endproperty
    a_blink: assert property (p_blink)
        else $error("slow link blink interval wrong");
    property p_enable;
        quiet_reg >= 4'h3 |-> LINK_STATE_INDICATOR_OE_B == {NUM_PORTS{
            cap_reg[3] || sel_reg != lsisc_pkg::GPIO_SEL_INDICATOR}};
    endproperty
    a_enable: assert property (p_enable)
        else $error("indicator drive enable wrong");
    property p_debug;
        s_settled |-> DEBUG_MODE == !cap_reg[4];
    endproperty
    a_debug: assert property (p_debug)
        else $error("debug mode does not follow strap");
    property p_vc_on;
        s_settled ##0 cap_reg[2] |-> SECOND_VC_OFFERED && !VC_SHARING_AVAILABLE;
    endproperty
    a_vc_on: assert property (p_vc_on)
        else $error("second channel not offered");
    property p_vc_off;
        s_settled ##0 !cap_reg[2] |-> !SECOND_VC_OFFERED && VC_SHARING_AVAILABLE;
    endproperty
    a_vc_off: assert property (p_vc_off)
        else $error("second channel not folded into channel zero");
    property p_pol;
        s_settled |-> POLARITY_DETECT_ENABLED == !cap_reg[1];
    endproperty
    a_pol: assert property (p_pol)
        else $error("polarity detect does not follow strap");
    property p_mps;
        s_settled |-> MAX_PAYLOAD_CODE == (cap_reg[0] ?
            lsisc_pkg::MPS_512B : lsisc_pkg::MPS_256B);
    endproperty
    a_mps: assert property (p_mps)
        else $error("payload code does not follow strap");
    property p_hold;
        age_reg == 2'h3 |-> $stable({SECOND_VC_OFFERED, VC_SHARING_AVAILABLE,
            POLARITY_DETECT_ENABLED, DEBUG_MODE, MAX_PAYLOAD_CODE});
    endproperty
    a_hold: assert property (p_hold)
        else $error("strap configuration changed after capture");
endmodule

bind lsisc_top lsisc_chk #(
    .BLINK_CYCLES(BLINK_CYCLES),
    .NUM_PORTS(NUM_PORTS)
) i_lsisc_chk (
    .SYS_CLK, .RST_B, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA,
    .HREADY, .LINK_UP, .LINK_FAST, .LINK_STATE_INDICATOR_I,
    .LINK_STATE_INDICATOR_O, .LINK_STATE_INDICATOR_OE_B,
    .SECOND_VIRTUAL_CHANNEL_ENABLE, .RECEIVE_POLARITY_DETECT_DISABLE,
    .LARGE_PAYLOAD_SELECT, .SECOND_VC_OFFERED, .VC_SHARING_AVAILABLE,
    .POLARITY_DETECT_ENABLED, .DEBUG_MODE, .MAX_PAYLOAD_CODE
);

// ===== tb_link_status_and_strap_config.sv
// testbench: link indicators, strap capture and register access
`timescale 1ns/1ps
module tb_link_status_and_strap_config;
    // --------
    // stimulus and design
    // --------
    localparam int unsigned BLINK = 8;
    typedef struct packed {
        logic [5:0] up;
        logic [5:0] fast;
        logic [5:0] exp_o;
    } lsisc_row_s;
    lsisc_row_s rows [6] = '{'{6'h00, 6'h00, 6'h3F}, '{6'h3F, 6'h3F, 6'h00},
        '{6'h15, 6'h3F, 6'h2A}, '{6'h2A, 6'h2A, 6'h15},
        '{6'h01, 6'h3F, 6'h3E}, '{6'h20, 6'h20, 6'h1F}};
    logic [4:0] cfg [2] = '{5'h08, 5'h17};
    logic clk = 1'h0;
    logic rst_b = 1'h0;
    logic hsel = 1'h0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic hreadyout, hresp;
    wire hready;
    logic [5:0] link_up = 6'h00;
    logic [5:0] link_fast = 6'h00;
    logic [5:0] ind_pin;
    logic [5:0] ind_o;
    logic [5:0] ind_oe_b;
    logic [4:0] strap = 5'h08;
    logic sec_vc;
    logic share;
    logic pol_en;
    logic dbg_mode;
    logic [2:0] mps;
    logic [31:0] rd, cap;
    int error_cnt = 0;
    int checked = 0;
    int cyc = 0;
    int n;

    assign hready = hreadyout;
    always #2.5 clk = ~clk;

    lsisc_top #(.BLINK_CYCLES(BLINK)) i_lsisc_top (
        .SYS_CLK(clk), .RST_B(rst_b), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
        .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
        .LINK_UP(link_up), .LINK_FAST(link_fast),
        .LINK_STATE_INDICATOR_I(ind_pin), .LINK_STATE_INDICATOR_O(ind_o),
        .LINK_STATE_INDICATOR_OE_B(ind_oe_b),
        .SECOND_VIRTUAL_CHANNEL_ENABLE(strap[2]),
        .RECEIVE_POLARITY_DETECT_DISABLE(strap[1]),
        .LARGE_PAYLOAD_SELECT(strap[0]), .SECOND_VC_OFFERED(sec_vc),
        .VC_SHARING_AVAILABLE(share), .POLARITY_DETECT_ENABLED(pol_en),
        .DEBUG_MODE(dbg_mode), .MAX_PAYLOAD_CODE(mps));
    lsisc_board i_lsisc_board (.ind_o(ind_o), .ind_oe_b(ind_oe_b),
        .dbg_lvl(strap[4]), .dis_lvl(strap[3]), .ind_pin(ind_pin));

    // --------
    // tasks
    // --------
    task automatic end_of_test;
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic settle(input int k);
        repeat (k) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic ahb(input logic wr, input logic [7:0] a,
        input logic [31:0] wd, output logic [31:0] r);
        @(posedge clk);
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= 32'(a);
        do @(posedge clk); while (hready !== 1'h1);
        htrans <= 2'h0;
        hsel <= 1'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'h1);
        r = hrdata;
    endtask

    task automatic do_reset(input logic [4:0] s);
        @(posedge clk);
        rst_b <= 1'h0;
        strap <= s;
        settle(4);
        chk("oe_b_rst", 32'(ind_oe_b), 32'h0000_003F);
        chk("o_rst", 32'(ind_o), 32'h0000_003F);
        @(posedge clk);
        rst_b <= 1'h1;
    endtask

    task automatic cfg_chk(input logic [4:0] s);
        chk("dbg", 32'(dbg_mode), 32'(!s[4]));
        chk("vc", 32'({sec_vc, share}), 32'({s[2], !s[2]}));
        chk("pol", 32'(pol_en), 32'(!s[1]));
        chk("mps", 32'(mps), 32'(cap[6:4]));
        chk("oe_b", 32'(ind_oe_b), s[3] ? 32'h0000_003F : 32'h0);
        ahb(1'h0, lsisc_pkg::CAPABILITY_OFS, 32'h0, rd);
        chk("cap", rd, cap);
        chk("resp", 32'(hresp), 32'h0000_0000);
        ahb(1'h0, lsisc_pkg::STRAP_STATUS_OFS, 32'h0, rd);
        chk("straps", rd, {15'h0, 1'h1, 5'h0, s[0], s[1], s[2], 4'h0, s[3],
            1'h0, s[4], 1'h1});
    endtask

    task automatic wait_flip(output int k);
        logic v;
        v = ind_o[2];
        k = 0;
        do begin @(negedge clk); k++; end while (ind_o[2] === v && k < 64);
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            end_of_test();
        end
    end

    // --------
    // sequence
    // --------
    initial begin
        for (int k = 0; k < 2; k++) begin
            do_reset(cfg[k]);
            cap = {25'h0, cfg[k][0] ? lsisc_pkg::MPS_512B : lsisc_pkg::MPS_256B,
                ~cfg[k][4], ~cfg[k][1], ~cfg[k][2], cfg[k][2]};
            settle(3);
            cfg_chk(cfg[k]);
            strap <= ~cfg[k];
            settle(3);
            cfg_chk(cfg[k]);
        end
        foreach (rows[i]) begin
            @(posedge clk);
            link_up <= rows[i].up;
            link_fast <= rows[i].fast;
            settle(2);
            chk("ind_o", 32'(ind_o), 32'(rows[i].exp_o));
            chk("ind_pin", 32'(ind_pin), 32'(rows[i].exp_o));
            ahb(1'h0, lsisc_pkg::LINK_STATUS_OFS, 32'h0, rd);
            chk("link", rd & 32'h01FF_FFFF, 32'({1'h1, 2'h0, rows[i].fast,
                2'h0, rows[i].up, 2'h0, rows[i].exp_o}));
        end
        ahb(1'h1, lsisc_pkg::CONTROL_OFS, 32'h0000_000A, rd);
        settle(3);
        chk("oe_b_sel", 32'(ind_oe_b), 32'h0000_003F);
        ahb(1'h0, lsisc_pkg::CONTROL_OFS, 32'h0, rd);
        chk("ctrl", rd, 32'h0000_000A);
        ahb(1'h1, lsisc_pkg::CAPABILITY_OFS, 32'hFFFF_FFFF, rd);
        ahb(1'h0, lsisc_pkg::CAPABILITY_OFS, 32'h0, rd);
        chk("cap_ro", rd, cap);
        ahb(1'h0, 8'h10, 32'h0, rd);
        chk("unmapped", rd, 32'h0);
        ahb(1'h1, lsisc_pkg::CONTROL_OFS, 32'h0000_000B, rd);
        settle(3);
        chk("oe_b_on", 32'(ind_oe_b), 32'h0);
        @(posedge clk);
        link_up <= 6'h14;
        link_fast <= 6'h10;
        settle(2);
        wait_flip(n);
        wait_flip(n);
        chk("blink", 32'(n), 32'(BLINK));
        wait_flip(n);
        chk("blink2", 32'(n), 32'(BLINK));
        chk("fast", 32'(ind_o[4]), 32'h0);
        end_of_test();
    end
endmodule
